// >>> hdl/eeprom_host_pkg.sv
// Constants for the paged EEPROM host controller.
// Assumes a 100 MHz system clock and a byte-wide memory on parallel pins.
package eeprom_host_pkg;

  // ***********************************************************************
  // Geometry
  // ***********************************************************************
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 8;
  localparam int CMD_ADDR_W = 15;
  localparam int POLL_BIT = 7;

  // ***********************************************************************
  // Timing
  // ***********************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int BYTE_LOAD_WINDOW_US = 150;
  localparam int PROGRAM_PERIOD_MS = 10;
  localparam int WRITE_PULSE_NS = 100;
  localparam int PULSE_HIGH_NS = 50;
  localparam int READ_ACCESS_NS = 250;
  // Longest time rounds down; least times round up.
  localparam int BYTE_LOAD_WINDOW_CYC =
    (BYTE_LOAD_WINDOW_US * 1000) / CLK_PERIOD_NS;
  localparam int PROGRAM_PERIOD_CYC =
    (PROGRAM_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_HIGH_CYC =
    (PULSE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_CYC =
    (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ***********************************************************************
  // Controller states
  // ***********************************************************************
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_SETUP = 6'b000010,
    ST_PULSE = 6'b000100,
    ST_HIGH  = 6'b001000,
    ST_READ  = 6'b010000,
    ST_POLL  = 6'b100000
  } host_state_t;

endpackage

// >>> hdl/eeprom_host.sv
// Host controller that writes and reads a paged EEPROM through its strobes.
// Assumes the memory pins are wired straight to this block's outputs.
//
// Behaviour
// [R1] Page number constant at every write strobe fall.
// [R2] Next byte load starts within load window.
// [R3] Output gate high while write strobes low.
// [R4] Lock arms at end of program period.
// [R5] Lock disarms at end of program period.
// [R6] Command bytes drive prescribed low address lines.
// [R7] Page number constant after protection command.
// [R8] Device floats data when chip or gate high.
// [R9] Device refuses write with gate low.
// [R10] Device latches data on first rising strobe.
// [R11] Polling read returns complemented poll bit.
// [R12] Device ignores loads while programming.
`timescale 1ns/1ns

module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter int PROG_CYC = PROGRAM_PERIOD_CYC,
  parameter int WINDOW_CYC = BYTE_LOAD_WINDOW_CYC
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // User request port.
  input wire logic i_req,
  input wire logic i_req_write,
  input wire logic i_req_last,
  input wire logic [eeprom_host_pkg::ADDR_W-1:0] i_req_addr,
  input wire logic [eeprom_host_pkg::DATA_W-1:0] i_req_wdata,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic o_rd_data_q_out_unused,
  output logic [eeprom_host_pkg::DATA_W-1:0] o_rd_data,
  output logic o_page_error,
  output logic o_busy,
  // Memory pins.
  output logic [eeprom_host_pkg::ADDR_W-1:0] o_mem_addr,
  output logic o_mem_ce_n,
  output logic o_mem_oe_n,
  output logic o_mem_we_n,
  output logic [eeprom_host_pkg::DATA_W-1:0] o_mem_dq,
  output logic o_mem_dq_oe,
  input wire logic [eeprom_host_pkg::DATA_W-1:0] i_mem_dq
);
  import eeprom_host_pkg::*;

  // ***********************************************************************
  // State
  // ***********************************************************************
  host_state_t state_q, state_d;
  logic [31:0] cnt_q;
  logic [31:0] win_q;
  logic in_page_q;
  logic [ADDR_W-PAGE_LSB-1:0] page_q;
  logic [DATA_W-1:0] last_data_q;
  logic [ADDR_W-1:0] last_addr_q;
  logic last_q;
  logic write_q;
  logic [31:0] prog_q;
  logic [7:0] low_cnt_q;

  // Request decode, kept as named wires.
  wire idle_w = (state_q == ST_IDLE);
  wire take_w = idle_w && i_req;
  wire page_mismatch_w = in_page_q &&
    (i_req_addr[ADDR_W-1:PAGE_LSB] != page_q);
  // A write to a different page while a page is open is refused, since
  // the device would merge it into the wrong page.
  wire take_wr_w = take_w && i_req_write && !page_mismatch_w; // R1 R7
  wire take_rd_w = take_w && !i_req_write && !in_page_q;
  wire accept_w = take_wr_w || take_rd_w;
  wire cnt_done_w = (cnt_q == 32'd0);
  wire prog_done_w = (prog_q == 32'd0);
  wire poll_ok_w = (i_mem_dq[POLL_BIT] == last_data_q[POLL_BIT]); // R11
  wire window_lapsed_w = in_page_q && (win_q == 32'd0); // R2

  // ***********************************************************************
  // Next state
  // ***********************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take_wr_w) state_d = ST_SETUP;
        else if (take_rd_w) state_d = ST_READ;
        else if (window_lapsed_w) state_d = ST_POLL;
      end
      ST_SETUP: state_d = ST_PULSE;
      ST_PULSE: if (cnt_done_w) state_d = ST_HIGH;
      ST_HIGH: begin
        if (cnt_done_w) state_d = last_q ? ST_POLL : ST_IDLE;
      end
      ST_READ: if (cnt_done_w) state_d = ST_IDLE;
      // Polling covers lock arming and disarming too: the lock only
      // changes once the program period is over, so the host waits.
      ST_POLL: begin
        if (cnt_done_w && (poll_ok_w || prog_done_w)) begin
          state_d = ST_IDLE; // R4 R5 R12
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // ***********************************************************************
  // Sequencing registers
  // ***********************************************************************
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 32'd0;
      win_q <= 32'd0;
      in_page_q <= 1'b0;
      page_q <= '0;
      last_data_q <= '0;
      last_addr_q <= '0;
      last_q <= 1'b0;
      write_q <= 1'b0;
      prog_q <= 32'd0;
    end else begin
      state_q <= state_d;
      // Polling is bounded by the program period plus one load window.
      // A command-only sequence writes nothing, so its poll bit may never
      // match; without this bound the controller would hang there.
      if (state_d == ST_POLL && state_q != ST_POLL) begin
        prog_q <= 32'(PROG_CYC + WINDOW_CYC);
      end else if (prog_q != 32'd0) begin
        prog_q <= prog_q - 32'd1;
      end
      if (take_wr_w) begin
        page_q <= i_req_addr[ADDR_W-1:PAGE_LSB];
        last_data_q <= i_req_wdata;
        last_addr_q <= i_req_addr;
        last_q <= i_req_last;
        write_q <= 1'b1;
      end else if (take_rd_w) begin
        write_q <= 1'b0;
      end
      // Counter reload per state; the program period runs on its own counter, prog_q.
      if (state_d != state_q) begin
        case (state_d)
          ST_PULSE: cnt_q <= 32'(WRITE_PULSE_CYC - 1);
          ST_HIGH: cnt_q <= 32'(PULSE_HIGH_CYC - 1);
          ST_READ: cnt_q <= 32'(READ_ACCESS_CYC - 1);
          ST_POLL: cnt_q <= 32'(READ_ACCESS_CYC - 1);
          default: cnt_q <= 32'd0;
        endcase
      end else if (!cnt_done_w) begin
        cnt_q <= cnt_q - 32'd1;
      end else if (state_q == ST_POLL) begin
        cnt_q <= 32'(READ_ACCESS_CYC - 1); // Re-sample poll bit.
      end
      // Load window restarts at every strobe fall, with margin for setup.
      if (state_q == ST_SETUP) begin
        in_page_q <= 1'b1;
        win_q <= 32'(WINDOW_CYC - WRITE_PULSE_CYC - PULSE_HIGH_CYC - 2); // R2
      end else if (state_d == ST_POLL) begin
        in_page_q <= 1'b0;
      end else if (win_q != 32'd0) begin
        win_q <= win_q - 32'd1;
      end
    end
  end

  // ***********************************************************************
  // Pin and user outputs, all registered
  // ***********************************************************************
  wire strobe_d = (state_d == ST_PULSE);
  wire read_d = (state_d == ST_READ) || (state_d == ST_POLL);
  wire active_d = (state_d != ST_IDLE);
  wire rd_done_w = (state_q == ST_READ) && cnt_done_w;

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_mem_addr <= '0;
      o_mem_ce_n <= 1'b1;
      o_mem_oe_n <= 1'b1;
      o_mem_we_n <= 1'b1;
      o_mem_dq <= '0;
      o_mem_dq_oe <= 1'b0;
      o_req_ready <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
      o_page_error <= 1'b0;
      o_busy <= 1'b0;
      o_rd_data_q_out_unused <= 1'b0;
    end else begin
      // Only accepted requests move the pins, so a refused one cannot
      // steer the address away from a poll that starts in the same cycle.
      if (accept_w) begin
        o_mem_addr <= i_req_addr; // R6
        o_mem_dq <= i_req_wdata;
      end else if (state_d == ST_POLL) begin
        o_mem_addr <= last_addr_q;
      end
      o_mem_we_n <= !strobe_d;
      o_mem_ce_n <= !(strobe_d || read_d);
      o_mem_oe_n <= !read_d; // R3
      o_mem_dq_oe <= (state_d == ST_SETUP) || strobe_d ||
        (state_d == ST_HIGH);
      o_req_ready <= !active_d && !take_w;
      o_rd_valid <= rd_done_w;
      if (rd_done_w) o_rd_data <= i_mem_dq;
      o_page_error <= take_w && i_req_write && page_mismatch_w;
      o_busy <= active_d || in_page_q;
      o_rd_data_q_out_unused <= write_q;
    end
  end

  // ***********************************************************************
  // Checks
  // ***********************************************************************
  // Counts how long the write strobe has been low, for the pulse check.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      low_cnt_q <= 8'h00;
    end else if (!o_mem_we_n) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end else begin
      low_cnt_q <= 8'h00;
    end
  end

  gate_high_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !o_mem_we_n |-> o_mem_oe_n) // R3
    else $error("Output gate low during a write strobe.");

  page_same_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $fell(o_mem_we_n) && $past(in_page_q) |->
    o_mem_addr[ADDR_W-1:PAGE_LSB] == page_q) // R1
    else $error("Page number changed inside a page load.");

  cmd_page_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $fell(o_mem_we_n) |-> $stable(page_q) || !$past(in_page_q)) // R7
    else $error("Page register moved at a strobe fall.");

  pulse_len_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $rose(o_mem_we_n) |-> low_cnt_q >= 8'(WRITE_PULSE_CYC)) // R2
    else $error("Write pulse too short.");

  win_ok_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    in_page_q |-> win_q < 32'(WINDOW_CYC)) // R2
    else $error("Load window overran.");

  poll_exit_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    state_q == ST_POLL && state_d == ST_IDLE |->
    i_mem_dq[POLL_BIT] == last_data_q[POLL_BIT] || prog_done_w) // R11
    else $error("Left polling before true data.");

  poll_bound_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    state_q == ST_POLL && cnt_done_w && prog_done_w |=> state_q == ST_IDLE) // R4
    else $error("Polling outlived its bound.");

  no_load_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    state_q == ST_POLL |-> o_mem_we_n && o_mem_dq_oe == 1'b0) // R12
    else $error("Byte load during programming.");

  lock_wait_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    state_q == ST_HIGH && cnt_done_w && last_q |=> state_q == ST_POLL) // R4
    else $error("Program period not awaited.");

endmodule // eeprom_host

// >>> test/mem_model.sv
// Behavioural paged memory that answers the host controller's pins.
// Assumes strobes come from a clocked host; all timing here is in ns.
`timescale 1ns/1ns
module mem_model #(
  parameter int WIN_NS = 1000,
  parameter int PROG_NS = 5000,
  parameter logic [14:0] CA1 = 15'h0155,
  parameter logic [14:0] CA2 = 15'h01aa,
  parameter logic [7:0] CD1 = 8'h5a,
  parameter logic [7:0] CD2 = 8'ha5,
  parameter logic [7:0] CON = 8'h3c,
  parameter logic [7:0] COFF = 8'hc3
) (
  // Pins from the host.
  input wire logic [18:0] i_a,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [7:0] i_d,
  // Data back to the host.
  output logic o_drv,
  output logic [7:0] o_q
);
  logic [7:0] mem [logic [18:0]];
  logic [18:0] qa [$];
  logic [7:0] qd [$];
  logic prog = 0;
  logic lock = 0;
  logic cmd;
  int nload = 0;
  time t_last;
  time t_end;
  wire wr = !i_ce_n && !i_we_n && i_oe_n;
  // Data lands on the first rising strobe; busy time ignores loads.
  always @(negedge wr) if (!prog) begin
    qa.push_back(i_a);
    qd.push_back(i_d);
    t_last = $time;
    nload++;
  end
  // A lapsed window starts programming; its end commits and sets or clears the lock.
  always #50 begin
    if (!prog && qa.size() > 0 && $time - t_last > WIN_NS) begin
      prog = 1;
      t_end = $time + PROG_NS;
    end else if (prog && $time >= t_end) begin
      cmd = qa.size() >= 3 && qa[0][14:0] == CA1 && qd[0] == CD1
        && qa[1][14:0] == CA2 && qd[1] == CD2 && qa[2][14:0] == CA1;
      if (cmd && qd[2] == CON) lock = 1;
      if (cmd && qd[2] == COFF) lock = 0;
      for (int i = cmd ? 3 : 0; i < qa.size(); i++)
        if (!lock || cmd) mem[qa[i]] = qd[i];
      prog = 0;
      qa.delete();
      qd.delete();
    end
  end
  // Output floats unless selected and gated; busy reads are polls.
  // Loads still waiting for the window count as busy, so an early poll
  // sees the complement instead of stale array data.
  assign o_drv = !i_ce_n && !i_oe_n && i_we_n;
  always @(i_a or prog or nload)
    o_q = (prog || qa.size() > 0) ? {~qd[$][7], qd[$][6:0]}
      : (mem.exists(i_a) ? mem[i_a] : 8'hff);
endmodule // mem_model

// >>> test/tb_top.sv
// Self-checking bench for the paged memory host controller.
// Assumes the behavioural memory model answers on the pins.
`timescale 1ns/1ns
module tb_top;
  import eeprom_host_pkg::*;
  logic clk = 0, rst = 1, req = 0, rw = 0, last = 0;
  logic [ADDR_W-1:0] ra = '0;
  logic [ADDR_W-1:0] ma;
  logic [DATA_W-1:0] wd = '0;
  logic [DATA_W-1:0] rdat, mdq, mq, din;
  logic rdy, rv, perr, ce_n, oe_n, we_n, doe, mdrv, bsy, wq;
  int mismatches = 0, n_compared = 0, n_err = 0;
  always #5 clk = ~clk;
  // A floating bus shows the inverse of the model's value, never a kept one.
  assign din = doe ? mdq : (mdrv ? mq : ~mq);
  eeprom_host #(.PROG_CYC(600), .WINDOW_CYC(100)) eeprom_host_i (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_req(req), .i_req_write(rw),
    .i_req_last(last), .i_req_addr(ra), .i_req_wdata(wd),
    .o_req_ready(rdy), .o_rd_valid(rv), .o_rd_data_q_out_unused(wq),
    .o_rd_data(rdat), .o_page_error(perr), .o_busy(bsy),
    .o_mem_addr(ma), .o_mem_ce_n(ce_n), .o_mem_oe_n(oe_n),
    .o_mem_we_n(we_n), .o_mem_dq(mdq), .o_mem_dq_oe(doe), .i_mem_dq(din));
  mem_model mem_model_i (.i_a(ma), .i_ce_n(ce_n), .i_oe_n(oe_n),
    .i_we_n(we_n), .i_d(mdq), .o_drv(mdrv), .o_q(mq));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Bounded wait on ready (f=0) or read valid (f=1), sampled mid-cycle.
  task automatic await(input int f, input int lim);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while ((f ? rv : rdy) !== 1'b1 && k < lim);
    if ((f ? rv : rdy) !== 1'b1) begin
      mismatches++;
      close_out();
    end
  endtask
  // One request; the extra edges let the registered ready catch up.
  task automatic put(input logic w, input logic l,
                     input logic [ADDR_W-1:0] a, input logic [7:0] d);
    await(0, 2000);
    @(posedge clk);
    req <= 1;
    rw <= w;
    last <= l;
    ra <= a;
    wd <= d;
    @(posedge clk);
    req <= 0;
    repeat (2) @(posedge clk);
  endtask
  task automatic get(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    put(0, 0, a, 8'h00);
    await(1, 100);
    check(rdat, e);
  endtask
  task automatic cmd(input logic [7:0] c3, input logic l);
    put(1, 0, 19'h00155, 8'h5a);
    put(1, 0, 19'h001aa, 8'ha5);
    put(1, l, 19'h00155, c3);
  endtask
  // The gate stays high across every load strobe; refusals are counted.
  always @(negedge clk) begin
    if (!rst && !we_n && !ce_n) check({7'h0, oe_n}, 8'h01);
    if (perr === 1'b1) n_err++;
  end
  initial begin
    repeat (5) @(posedge clk);
    check({4'h0, ce_n, oe_n, we_n, doe}, 8'h0e);
    rst <= 0;
    put(1, 0, 19'h00110, 8'h81);
    put(1, 0, 19'h00111, 8'h02);
    put(1, 1, 19'h00112, 8'h93);
    get(19'h00110, 8'h81);
    get(19'h00112, 8'h93);
    put(1, 0, 19'h00220, 8'h44);
    put(1, 0, 19'h00320, 8'h55);
    check(n_err[7:0], 8'h01);
    put(1, 1, 19'h00221, 8'h66);
    get(19'h00221, 8'h66);
    get(19'h00320, 8'hff);
    put(1, 0, 19'h00400, 8'h77);
    @(negedge clk);
    check({6'h00, bsy, wq}, 8'h03);
    // Reads are refused while the page is open; let the window lapse.
    repeat (100) @(posedge clk);
    get(19'h00400, 8'h77);
    check({6'h00, bsy, wq}, 8'h00);
    cmd(8'h3c, 1);
    put(1, 1, 19'h00130, 8'h99);
    get(19'h00130, 8'hff);
    cmd(8'hc3, 0);
    put(1, 1, 19'h00131, 8'h88);
    get(19'h00131, 8'h88);
    put(1, 1, 19'h00132, 8'h77);
    get(19'h00132, 8'h77);
    close_out();
  end
endmodule // tb_top
